//--- logic/sfw_core.v
// Serial NOR flash command core: decode, array, program and erase engine.
//
// Functional notes
// (RULE1) 3B, address, dummy, then two-bit reads
// (RULE2) Host holds select low through a command
// (RULE3) 02, address, then up to 256 bytes
// (RULE4) Program offset wraps inside the same page
// (RULE5) Only the last 256 bytes are kept
// (RULE6) Writes to protected regions are discarded
// (RULE7) Host sends write enable before writes
// (RULE8) Program and erase start at select rise
// (RULE9) Busy is one during the internal cycle
// (RULE10) Program end clears the write latch
// (RULE11) D8 erases the 64K block to FF
// (RULE12) 20 erases the 4K sector to FF
// (RULE13) 60 or C7 erase all, unless protected
// (RULE14) Status reads anytime, repeated until select rises; the code ignores them during sleep
// (RULE15) Write enable sets the latch at rise
// (RULE16) Write disable clears the latch at rise
// (RULE17) Status write ignored when pin low, locked
// (RULE18) Pin low: lock bit only goes 0 to 1
// (RULE19) Unlocked status write changes all fields
// (RULE20) B9 then select rise enters sleep
// (RULE21) Sleep ignores all but wake and signature; the code serves only wake (AB) and has no signature read
// (RULE22) Reset always leaves the device awake
// (RULE23) Status write follows write enable directly
// (RULE24) Status write clears the write latch
// (RULE25) Erase end clears latch; busy throughout
// (RULE26) Opcodes MSB first; unknown ones ignored
`timescale 1ns/1ps
`include "sfw_regs.vh"
module sfw_core #(
  parameter AW = 18,
  parameter TW = 26,
  parameter [TW-1:0] PAGE_CYC = `SFW_PAGE_WRITE_CYC,
  parameter [TW-1:0] SECTOR_CYC = `SFW_SECTOR_ERASE_CYC,
  parameter [TW-1:0] BLOCK_CYC = `SFW_BLOCK_ERASE_CYC,
  parameter [TW-1:0] CHIP_CYC = `SFW_CHIP_ERASE_CYC,
  parameter [TW-1:0] SLEEP_CYC = `SFW_SLEEP_ENTRY_CYC
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire spi_cs_b_i,
  input wire spi_sck_i,
  input wire spi_io0_i,
  input wire spi_wp_b_i,
  output wire spi_io0_o,
  output wire spi_io0_oe_o,
  output wire spi_io1_o,
  output wire spi_io1_oe_o,
  output wire busy_o,
  output wire sleep_o,
  output wire [7:0] status_o
);
  localparam NB = 1 << (AW - `SFW_BLOCK_BITS);
  localparam [1:0] ENG_IDLE = 2'h0;
  localparam [1:0] ENG_WALK = 2'h1;
  localparam [1:0] ENG_WAIT = 2'h2;

  // ==========================================================
  // Pin sampling and edge detection
  // ==========================================================
  wire [3:0] pin_s;
  wire cs_b_s;
  wire sck_s;
  wire io0_s;
  wire wp_b_s;
  reg sck_d_q;
  reg cs_d_q;

  sfw_sync #(.W(4), .RST_VAL(`SFW_STATUS_RST)) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({spi_wp_b_i, spi_io0_i, spi_sck_i, spi_cs_b_i}),
    .sync_o(pin_s)
  );
  assign cs_b_s = pin_s[0];
  assign sck_s = pin_s[1];
  assign io0_s = pin_s[2];
  assign wp_b_s = pin_s[3];

  // Delayed copies give clock and select edges.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      sck_d_q <= sck_s;
      cs_d_q <= cs_b_s;
    end
  end

  wire sck_rise = sck_s && !sck_d_q && !cs_b_s;
  wire sck_fall = !sck_s && sck_d_q && !cs_b_s;
  wire cs_rise = cs_b_s && !cs_d_q;

  // ==========================================================
  // State and storage
  // ==========================================================
  reg [2:0] bit_q;
  reg [8:0] byte_q;
  reg [6:0] sh_q;
  reg [7:0] op_q;
  reg [23:0] addr_q;
  reg [7:0] pg_off_q;
  reg [7:0] wsr_q;
  reg [7:0] out_sr_q;
  reg out_en_q;
  reg dual_q;
  reg io0_q;
  reg io1_q;
  reg wel_q;
  reg [2:0] bp_q;
  reg tb_q;
  reg bpl_q;
  reg sleep_q;
  reg [255:0] pmask_q;
  reg [1:0] eng_st_q;
  reg prog_q;
  reg [AW-1:0] wa_q;
  reg [AW-1:0] wend_q;
  reg [7:0] mem [0:(1<<AW)-1];
  reg [7:0] pbuf [0:255];

  wire busy = (eng_st_q != ENG_IDLE);
  wire [7:0] rx_byte = {sh_q, io0_s}; // RULE26
  wire byte_done = sck_rise && (bit_q == 3'h7);
  wire [7:0] op_n = (byte_q == 9'h000) ? rx_byte : op_q;
  wire whole = (bit_q == 3'h0);
  wire [7:0] mem_rd = mem[addr_q[AW-1:0]];
  wire [7:0] status = {bpl_q, 1'b0, tb_q, bp_q, wel_q, busy};
  wire tmr_run;
  wire slp_done;

  // Protected blocks grow from the top, or the bottom when tb is set.
  function prot_hit;
    input [AW-17:0] blk;
    integer n;
    begin
      n = (bp_q == 3'h0) ? 0 : (bp_q == 3'h1) ? 1 : (bp_q == 3'h2) ? 2 : NB;
      if (n > NB) n = NB;
      if (tb_q) prot_hit = (blk < n);
      else prot_hit = (blk >= NB - n);
    end
  endfunction

  // ==========================================================
  // Command execution at select rise
  // ==========================================================
  wire cmd_ok = cs_rise && whole && !sleep_q && !busy; // RULE8 RULE21
  wire wr_ok = cmd_ok && wel_q;
  wire blk_prot = prot_hit(addr_q[AW-1:16]);
  wire go_prog = wr_ok && (op_q == `SFW_OP_PAGE_WRITE) && (byte_q > 9'h004) && !blk_prot; // RULE3 RULE6
  wire go_sect = wr_ok && (op_q == `SFW_OP_SECTOR_ERASE) && (byte_q == 9'h004) && !blk_prot; // RULE6
  wire go_block = wr_ok && (op_q == `SFW_OP_BLOCK_ERASE) && (byte_q == 9'h004) && !blk_prot; // RULE6
  wire go_chip = wr_ok && ((op_q == `SFW_OP_CHIP_ERASE_A) || (op_q == `SFW_OP_CHIP_ERASE_B))
                 && (byte_q == 9'h001) && (bp_q == 3'h0); // RULE13
  wire go_wsr = wr_ok && (op_q == `SFW_OP_STATUS_WRITE) && (byte_q == 9'h002)
                && !(!wp_b_s && bpl_q); // RULE17
  wire go_set = cmd_ok && (op_q == `SFW_OP_SET_LATCH) && (byte_q == 9'h001);
  wire go_clr = cmd_ok && (op_q == `SFW_OP_CLEAR_LATCH) && (byte_q == 9'h001);
  wire go_sleep = cmd_ok && (op_q == `SFW_OP_SLEEP) && (byte_q == 9'h001); // RULE20
  wire go_wake = cs_rise && whole && sleep_q && (op_q == `SFW_OP_WAKE) && (byte_q == 9'h001);
  wire go_any = go_prog || go_sect || go_block || go_chip;
  wire eng_fin = (eng_st_q == ENG_WAIT) && !tmr_run;
  wire pg_wr = byte_done && !sleep_q && !busy && (op_q == `SFW_OP_PAGE_WRITE) && (byte_q >= 9'h004);
  wire dual_ld = sck_rise && !sleep_q && !busy && ((byte_done && (byte_q == `SFW_DUMMY_BYTE)
                 && (op_q == `SFW_OP_DUAL_READ)) || (dual_q && (bit_q[1:0] == 2'h3)));

  reg [AW-1:0] st_a;
  reg [AW-1:0] en_a;
  reg [TW-1:0] ld_c;
  // Address range and duration of the internal cycle being started.
  always @* begin
    st_a = {addr_q[AW-1:`SFW_PAGE_BITS], 8'h00};
    en_a = {addr_q[AW-1:`SFW_PAGE_BITS], 8'hff};
    ld_c = PAGE_CYC;
    if (go_sect) begin
      st_a = {addr_q[AW-1:`SFW_SECTOR_BITS], 12'h000}; // RULE12
      en_a = {addr_q[AW-1:`SFW_SECTOR_BITS], 12'hfff};
      ld_c = SECTOR_CYC;
    end else if (go_block) begin
      st_a = {addr_q[AW-1:`SFW_BLOCK_BITS], 16'h0000}; // RULE11
      en_a = {addr_q[AW-1:`SFW_BLOCK_BITS], 16'hffff};
      ld_c = BLOCK_CYC;
    end else if (go_chip) begin
      st_a = {AW{1'b0}}; // RULE13
      en_a = {AW{1'b1}};
      ld_c = CHIP_CYC;
    end
  end

  sfw_timer #(.W(TW)) u_tmr (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(go_any),
    .load_i(ld_c),
    .run_o(tmr_run),
    .done_o()
  );

  sfw_timer #(.W(TW)) u_slp (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .start_i(go_sleep),
    .load_i(SLEEP_CYC),
    .run_o(),
    .done_o(slp_done)
  );

  // ==========================================================
  // Serial shifter, byte decode and output shifter
  // ==========================================================
  // Counters clear whenever select is high, so a frame always restarts cleanly.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_q <= 3'h0;
      byte_q <= 9'h000;
      sh_q <= 7'h00;
      op_q <= 8'h00;
      addr_q <= 24'h000000;
      pg_off_q <= 8'h00;
      wsr_q <= 8'h00;
      out_sr_q <= 8'h00;
      out_en_q <= 1'b0;
      dual_q <= 1'b0;
      io0_q <= 1'b0;
      io1_q <= 1'b0;
      pmask_q <= 256'h0;
    end else if (cs_b_s) begin
      bit_q <= 3'h0;
      byte_q <= 9'h000;
      out_en_q <= 1'b0;
      dual_q <= 1'b0;
    end else if (sck_rise) begin
      sh_q <= rx_byte[6:0];
      bit_q <= bit_q + 3'h1;
      if (byte_done && (byte_q != 9'h1ff)) byte_q <= byte_q + 9'h001;
      if (byte_done && (byte_q == 9'h000)) op_q <= rx_byte; // RULE26
      if (byte_done && (byte_q == 9'h000) && (rx_byte == `SFW_OP_PAGE_WRITE)) begin
        pmask_q <= 256'h0;
      end
      if (byte_done && (byte_q != 9'h000) && (byte_q < `SFW_DUMMY_BYTE)) begin
        addr_q <= {addr_q[15:0], rx_byte};
      end else if (dual_ld) begin
        addr_q <= addr_q + 24'h000001; // RULE1
      end
      if (byte_done && (op_q == `SFW_OP_PAGE_WRITE) && (byte_q == 9'h003)) begin
        pg_off_q <= rx_byte;
      end else if (pg_wr) begin
        pg_off_q <= pg_off_q + 8'h01; // RULE4 RULE5
        pmask_q[pg_off_q] <= 1'b1;
      end
      if (byte_done && (op_q == `SFW_OP_STATUS_WRITE) && (byte_q == 9'h001)) wsr_q <= rx_byte;
      if (byte_done && (op_n == `SFW_OP_STATUS_READ) && !sleep_q) begin
        out_sr_q <= status; // RULE14 RULE9
        out_en_q <= 1'b1;
      end else if (dual_ld) begin
        out_sr_q <= mem_rd; // RULE1
        out_en_q <= 1'b1;
        dual_q <= 1'b1;
      end
    end else if (sck_fall) begin
      io1_q <= out_sr_q[7];
      if (dual_q) begin
        io0_q <= out_sr_q[6]; // RULE1
        out_sr_q <= {out_sr_q[5:0], 2'h0};
      end else begin
        out_sr_q <= {out_sr_q[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // Status register and power state
  // ==========================================================
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wel_q <= 1'b0;
      bp_q <= 3'h0;
      tb_q <= 1'b0;
      bpl_q <= 1'b0;
      sleep_q <= 1'b0; // RULE22
    end else begin
      if (go_set) begin
        wel_q <= 1'b1; // RULE15
      end else if (go_clr || go_wsr || eng_fin) begin
        wel_q <= 1'b0; // RULE16 RULE24 RULE10 RULE25
      end
      if (go_wsr) begin
        bp_q <= wsr_q[`SFW_ST_BP_LSB+2:`SFW_ST_BP_LSB]; // RULE19
        tb_q <= wsr_q[`SFW_ST_TB];
        bpl_q <= wsr_q[`SFW_ST_BPL]; // RULE18
      end
      if (slp_done) begin
        sleep_q <= 1'b1; // RULE20
      end else if (go_wake) begin
        sleep_q <= 1'b0; // RULE21
      end
    end
  end

  // ==========================================================
  // Program and erase engine
  // ==========================================================
  // Walk the target range, then hold busy until the timer runs out.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      eng_st_q <= ENG_IDLE;
      prog_q <= 1'b0;
      wa_q <= {AW{1'b0}};
      wend_q <= {AW{1'b0}};
    end else begin
      case (eng_st_q)
        ENG_IDLE: begin
          if (go_any) begin
            eng_st_q <= ENG_WALK; // RULE8
            wa_q <= st_a;
            wend_q <= en_a;
            prog_q <= go_prog;
          end
        end
        ENG_WALK: begin
          if (wa_q == wend_q) eng_st_q <= ENG_WAIT;
          else wa_q <= wa_q + {{(AW-1){1'b0}}, 1'b1};
        end
        ENG_WAIT: begin
          if (!tmr_run) eng_st_q <= ENG_IDLE; // RULE9 RULE25
        end
        default: begin
          eng_st_q <= ENG_IDLE;
        end
      endcase
    end
  end

  // Array writes: erase sets bytes, program only clears bits of marked bytes.
  always @(posedge ref_clk_i) begin
    if (eng_st_q == ENG_WALK) begin
      if (!prog_q) begin
        mem[wa_q] <= `SFW_ERASED; // RULE11 RULE12 RULE13
      end else if (pmask_q[wa_q[7:0]]) begin
        mem[wa_q] <= mem[wa_q] & pbuf[wa_q[7:0]]; // RULE5
      end
    end
  end

  // Page buffer fill; wrapping offsets leave only the newest 256 bytes.
  always @(posedge ref_clk_i) begin
    if (pg_wr) pbuf[pg_off_q] <= rx_byte; // RULE4
  end

  assign spi_io1_o = io1_q;
  assign spi_io1_oe_o = out_en_q;
  assign spi_io0_o = io0_q;
  assign spi_io0_oe_o = dual_q;
  assign busy_o = busy;
  assign sleep_o = sleep_q;
  assign status_o = status;
endmodule // sfw_core

//--- logic/sfw_regs.vh
// Opcodes, status bit positions and timing counts for the serial flash command core.
`ifndef SFW_REGS_VH
`define SFW_REGS_VH
`define SFW_OP_DUAL_READ 8'h3b
`define SFW_OP_PAGE_WRITE 8'h02
`define SFW_OP_BLOCK_ERASE 8'hd8
`define SFW_OP_SECTOR_ERASE 8'h20
`define SFW_OP_CHIP_ERASE_A 8'h60
`define SFW_OP_CHIP_ERASE_B 8'hc7
`define SFW_OP_STATUS_READ 8'h05
`define SFW_OP_STATUS_WRITE 8'h01
`define SFW_OP_SET_LATCH 8'h06
`define SFW_OP_CLEAR_LATCH 8'h04
`define SFW_OP_SLEEP 8'hb9
`define SFW_OP_WAKE 8'hab
`define SFW_ST_BUSY 0
`define SFW_ST_WEL 1
`define SFW_ST_BP_LSB 2
`define SFW_ST_TB 5
`define SFW_ST_BPL 7
`define SFW_ERASED 8'hff
`define SFW_PAGE_BITS 8
`define SFW_SECTOR_BITS 12
`define SFW_BLOCK_BITS 16
`define SFW_DUMMY_BYTE 9'h004
`define SFW_STATUS_RST 4'h9
`define SFW_CLK_MHZ 25
`define SFW_PAGE_WRITE_TIME_US 1500
`define SFW_SECTOR_ERASE_TIME_US 150000
`define SFW_BLOCK_ERASE_TIME_US 750000
`define SFW_CHIP_ERASE_TIME_US 2000000
`define SFW_SLEEP_ENTRY_DELAY_US 3
`define SFW_PAGE_WRITE_CYC (`SFW_PAGE_WRITE_TIME_US * `SFW_CLK_MHZ)
`define SFW_SECTOR_ERASE_CYC (`SFW_SECTOR_ERASE_TIME_US * `SFW_CLK_MHZ)
`define SFW_BLOCK_ERASE_CYC (`SFW_BLOCK_ERASE_TIME_US * `SFW_CLK_MHZ)
`define SFW_CHIP_ERASE_CYC (`SFW_CHIP_ERASE_TIME_US * `SFW_CLK_MHZ)
`define SFW_SLEEP_ENTRY_CYC (`SFW_SLEEP_ENTRY_DELAY_US * `SFW_CLK_MHZ)
`endif

//--- logic/sfw_sync.v
// Two-flop synchroniser bank for the serial pins.
`timescale 1ns/1ps
module sfw_sync #(
  parameter W = 4,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  genvar g;
  // ==========================================================
  // Per-bit synchroniser
  // ==========================================================
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      // The first stage feeds only the second stage.
      always @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          s1_q <= RST_VAL[g];
          s2_q <= RST_VAL[g];
        end else begin
          s1_q <= async_i[g];
          s2_q <= s1_q;
        end
      end
      assign sync_o[g] = s2_q;
    end
  endgenerate
endmodule // sfw_sync

//--- logic/sfw_timer.v
// Down counter that times the self-timed internal cycles.
`timescale 1ns/1ps
module sfw_timer #(
  parameter W = 26
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire start_i,
  input wire [W-1:0] load_i,
  output wire run_o,
  output wire done_o
);
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  reg [W-1:0] cnt_q;
  reg done_q;
  // ==========================================================
  // Counter
  // ==========================================================
  // A start reloads the count; done pulses once as it runs out.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= {W{1'b0}};
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == ONE) && !start_i;
      if (start_i) begin
        cnt_q <= load_i;
      end else if (cnt_q != {W{1'b0}}) begin
        cnt_q <= cnt_q - ONE;
      end
    end
  end
  assign run_o = (cnt_q != {W{1'b0}});
  assign done_o = done_q;
endmodule // sfw_timer

//--- verification/sfw_core_props.sv
// Concurrent checks on the ports of the serial flash command core.
`timescale 1ns/1ps
module sfw_core_props #(
  parameter int PAGE_CYC = 37500
) (
  input wire ref_clk_i,
  input wire rst_b_i,
  input wire spi_cs_b_i,
  input wire spi_sck_i,
  input wire spi_io0_i,
  input wire spi_wp_b_i,
  input wire spi_io0_o,
  input wire spi_io0_oe_o,
  input wire spi_io1_o,
  input wire spi_io1_oe_o,
  input wire busy_o,
  input wire sleep_o,
  input wire [7:0] status_o
);
  int busy_len_q;
  // Counts the cycles of the current busy spell.
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_len_q <= 0;
    end else begin
      busy_len_q <= busy_o ? busy_len_q + 1 : 0;
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  busy_needs_latch_a: assert property ($rose(busy_o) |-> status_o[1])
    else $error("internal cycle started without the write latch");
  busy_start_a: assert property ($rose(busy_o) |-> $past(spi_cs_b_i))
    else $error("busy rose while select was low");
  busy_span_a: assert property ($fell(busy_o) |-> busy_len_q >= PAGE_CYC - 4)
    else $error("internal cycle ended too early");
  latch_set_a: assert property ($rose(status_o[1]) |-> $past(spi_cs_b_i))
    else $error("write latch set inside a frame");
  latch_clear_a: assert property ($fell(status_o[1]) |-> $past(spi_cs_b_i) || $fell(busy_o))
    else $error("write latch cleared at an odd moment");
  prot_stable_a: assert property ($changed(status_o[7:2]) |-> $past(spi_cs_b_i))
    else $error("protect bits changed inside a frame");
  dual_pair_a: assert property (spi_io0_oe_o |-> spi_io1_oe_o)
    else $error("io0 driven without io1");
  idle_release_a: assert property (spi_cs_b_i [*8] |-> !spi_io0_oe_o && !spi_io1_oe_o)
    else $error("data lines driven while deselected");
  sleep_enter_a: assert property ($rose(sleep_o) |-> spi_cs_b_i && !busy_o)
    else $error("sleep entered at an odd moment");
  sleep_leave_a: assert property ($fell(sleep_o) |-> $past(spi_cs_b_i))
    else $error("sleep left inside a frame");
  // The pin synchroniser lags two cycles, so the protect pin is looked at three back.
  lock_release_a: assert property ($fell(status_o[7]) |-> $past(spi_wp_b_i, 3))
    else $error("lock bit cleared while write protect was low");
  io_hold_a: assert property (spi_sck_i [*4] |-> $stable(spi_io1_o) && $stable(spi_io0_o))
    else $error("data lines changed while the serial clock stood high");
  cover property ($rose(busy_o));
  cover property ($rose(sleep_o));
  cover property ($rose(spi_io0_oe_o));
endmodule // sfw_core_props

bind sfw_core sfw_core_props #(.PAGE_CYC(PAGE_CYC)) i_sfw_core_props (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .spi_cs_b_i(spi_cs_b_i), .spi_sck_i(spi_sck_i),
  .spi_io0_i(spi_io0_i), .spi_wp_b_i(spi_wp_b_i), .spi_io0_o(spi_io0_o),
  .spi_io0_oe_o(spi_io0_oe_o), .spi_io1_o(spi_io1_o), .spi_io1_oe_o(spi_io1_oe_o),
  .busy_o(busy_o), .sleep_o(sleep_o), .status_o(status_o));

//--- verification/sfw_core_test.sv
// Self-checking bench for the serial flash command core.
`timescale 1ns/1ps
`include "sfw_regs.vh"
`define SFW_CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
  $display("FAIL %s expected %h seen %h", nm, exp, got); end end
module sfw_core_test;
  typedef logic [7:0] sfw_bytes_t[$];
  logic ref_clk_i, rst_b_i, wp_b;
  logic [7:0] rx;
  wire cs_b, sck, host_io0, dev_io0, io0_oe, dev_io1, io1_oe, busy, sleep;
  wire [7:0] status;
  wire io0_w = io0_oe ? dev_io0 : host_io0;
  wire io1_w = io1_oe ? dev_io1 : 1'bz;
  int err_total, tests_run;
  sfw_bytes_t bad[5];
  sfw_bytes_t pg;
  // Short program and sector times keep the run brief; block and chip erase are only refused.
  sfw_core #(.PAGE_CYC(26'd300), .SECTOR_CYC(26'd300)) i_sfw_core (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .spi_cs_b_i(cs_b), .spi_sck_i(sck),
    .spi_io0_i(io0_w), .spi_wp_b_i(wp_b), .spi_io0_o(dev_io0), .spi_io0_oe_o(io0_oe),
    .spi_io1_o(dev_io1), .spi_io1_oe_o(io1_oe), .busy_o(busy), .sleep_o(sleep),
    .status_o(status));
  sfw_host i_host (.ref_clk_i(ref_clk_i), .cs_b_o(cs_b), .sck_o(sck), .io0_o(host_io0),
    .io0_i(io0_w), .io1_i(io1_w));
  // Free-running system clock at 25 MHz.
  initial begin
    ref_clk_i = 1'b0;
    forever #20 ref_clk_i = ~ref_clk_i;
  end
  // ==========================================================
  // Access tasks
  task automatic run(input sfw_bytes_t q);
    i_host.open_frame();
    foreach (q[k]) i_host.put_byte(q[k], rx);
    i_host.close_frame();
  endtask
  task automatic wr(input sfw_bytes_t q);
    run('{`SFW_OP_SET_LATCH});
    run(q);
  endtask
  // Reads the status twice in one frame to see it repeat.
  task automatic rd_status(input logic [7:0] exp);
    i_host.open_frame();
    i_host.put_byte(`SFW_OP_STATUS_READ, rx);
    repeat (2) begin
      i_host.put_byte(8'h00, rx);
      `SFW_CHK("status read", exp, rx)
    end
    i_host.close_frame();
  endtask
  task automatic rd_dual(input logic [23:0] a, input sfw_bytes_t exp);
    i_host.open_frame();
    i_host.put_byte(`SFW_OP_DUAL_READ, rx);
    for (int k = 16; k >= 0; k -= 8) i_host.put_byte(a[k+:8], rx);
    i_host.put_byte(8'h00, rx);
    foreach (exp[k]) begin
      i_host.get_dual(rx);
      `SFW_CHK("dual read", exp[k], rx)
    end
    i_host.close_frame();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    `SFW_CHK("idle wait", 1'b0, busy)
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Cuts a hung run short well past the expected length.
  initial begin
    #2500000;
    err_total++;
    tally_and_finish();
  end
  // ==========================================================
  // Test sequence
  initial begin
    rst_b_i = 1'b0;
    wp_b = 1'b1;
    err_total = 0;
    tests_run = 0;
    bad[0] = '{8'h02, 8'h00, 8'h00, 8'h10, 8'h00};
    bad[1] = '{8'hd8, 8'h00, 8'h00, 8'h00};
    bad[2] = '{8'h20, 8'h00, 8'h00, 8'h00};
    bad[3] = '{8'h60};
    bad[4] = '{8'hc7};
    repeat (10) @(posedge ref_clk_i);
    #1 rst_b_i = 1'b1;
    i_host.tick(4);
    `SFW_CHK("sleep", 1'b0, sleep)
    run('{8'h06}); rd_status(8'h02);
    run('{8'h04}); rd_status(8'h00);
    run('{8'h77, 8'h06}); rd_status(8'h00);
    wr('{8'h20, 8'h00, 8'h0a, 8'hbc}); rd_status(8'h03);
    wait_idle(); rd_status(8'h00);
    rd_dual(24'h000ffe, '{8'hff, 8'hff});
    wr('{8'h02, 8'h00, 8'h00, 8'hfe, 8'ha5, 8'h5a, 8'h3c}); rd_status(8'h03);
    wait_idle(); rd_status(8'h00);
    rd_dual(24'h0000fe, '{8'ha5, 8'h5a});
    rd_dual(24'h000000, '{8'h3c, 8'hff});
    pg = '{8'h02, 8'h00, 8'h02, 8'h00};
    for (int n = 0; n < 256; n++) pg.push_back(n[7:0]);
    pg.push_back(8'h5a);
    wr(pg); wait_idle();
    rd_dual(24'h000200, '{8'h5a, 8'h01});
    wr('{8'h01, 8'h24}); rd_status(8'h24);
    foreach (bad[k]) begin
      wr(bad[k]);
      `SFW_CHK("busy", 1'b0, busy)
    end
    rd_dual(24'h000010, '{8'hff});
    wp_b = 1'b0;
    wr('{8'h01, 8'ha4}); rd_status(8'ha4);
    wr('{8'h01, 8'h00}); rd_status(8'ha6);
    wp_b = 1'b1;
    wr('{8'h01, 8'h00}); rd_status(8'h00);
    run('{8'hb9});
    i_host.tick(90);
    `SFW_CHK("sleep", 1'b1, sleep)
    run('{8'h06});
    `SFW_CHK("status", 8'h00, status)
    run('{8'hab});
    `SFW_CHK("sleep", 1'b0, sleep)
    tally_and_finish();
  end
endmodule // sfw_core_test

//--- verification/sfw_host.sv
// Host controller model that frames commands towards the flash core.
`timescale 1ns/1ps
module sfw_host (
  input wire ref_clk_i,
  output logic cs_b_o,
  output logic sck_o,
  output logic io0_o,
  input wire io0_i,
  input wire io1_i
);
  // Select idles high and the serial clock stands low between frames.
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    io0_o = 1'b0;
  end
  // ==========================================================
  // Link tasks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic open_frame();
    tick(1);
    cs_b_o = 1'b0;
    tick(4);
  endtask
  // Select stays low for the whole sequence and rises to launch it.
  task automatic close_frame();
    tick(4);
    cs_b_o = 1'b1;
    io0_o = ~io0_o;
    tick(8);
  endtask
  task automatic put_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      io0_o = tx[i];
      tick(4);
      sck_o = 1'b1;
      rx[i] = io1_i;
      tick(4);
      sck_o = 1'b0;
    end
  endtask
  // The data line is let go with a changing pattern while the core drives it.
  task automatic get_dual(output logic [7:0] rx);
    io0_o = ~io0_o;
    for (int i = 3; i >= 0; i--) begin
      tick(4);
      sck_o = 1'b1;
      rx[2*i+1] = io1_i;
      rx[2*i] = io0_i;
      tick(4);
      sck_o = 1'b0;
    end
  endtask
endmodule // sfw_host
